// ===== hw/pme_wake_pkg.sv
/*
 * Constants shared by the wake-event block: register indices, byte
 * addresses, reset values and field positions.
 * Assumes a 32-bit APB with word-aligned registers.
 */
package pme_wake_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int SYNC_W = 2;

  typedef logic [REG_W-1:0]  reg8_t;
  typedef logic [ADDR_W-1:0] addr_t;

  // Register indices; byte address is four times the index
  localparam addr_t IDX_EVT_STS  = 8'h09;
  localparam addr_t IDX_WAKE_EN  = 8'h0a;
  localparam addr_t IDX_WAKE_STS = 8'h10;
  localparam addr_t IDX_GLB_CTRL = 8'h11;
  localparam addr_t IDX_IRQ_MASK = 8'h12;

  // Reset values (standby-power reset)
  localparam reg8_t EVT_STS_RST  = 8'h01;
  localparam reg8_t WAKE_EN_RST  = 8'h00;
  localparam reg8_t WAKE_STS_RST = 8'h00;
  localparam reg8_t GLB_CTRL_RST = 8'h00;
  localparam reg8_t IRQ_MASK_RST = 8'h00;

  // Field positions
  localparam int BIT_PARALLEL = 0;
  localparam int BIT_GLB_EN   = 0;

  function automatic addr_t byte_addr(input addr_t idx);
    byte_addr = addr_t'(idx << 2);
  endfunction : byte_addr

endpackage : pme_wake_pkg

// ===== hw/reg_access_if.sv
/*
 * Carrier between the APB slave and the register core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface reg_access_if;
  import pme_wake_pkg::*;
  logic  wr_en;   // One-cycle write strobe
  addr_t idx;     // Register index
  reg8_t wdata;   // Write data, low byte
  reg8_t rdata;   // Read data for idx
  logic  hit;     // idx is mapped

  modport bus_side  (output wr_en, idx, wdata, input rdata, hit);
  modport core_side (input wr_en, idx, wdata, output rdata, hit);
endinterface : reg_access_if

// ===== hw/apb_reg_slave.sv
/*
 * APB slave: one wait-free access phase, read data captured in the
 * setup cycle, unmapped addresses answered with pslverr.
 * Assumes a master that follows APB setup/access sequencing.
 */
`timescale 1ns/1ps
module apb_reg_slave (
  input  wire logic                      mclk_i,    // Clock
  input  wire logic                      sys_rst_i, // Async reset
  input  wire logic                      psel_i,    // Select
  input  wire logic                      penable_i, // Access phase
  input  wire logic                      pwrite_i,  // Write
  input  wire pme_wake_pkg::addr_t       paddr_i,   // Byte address
  input  wire logic [pme_wake_pkg::DATA_W-1:0] pwdata_i, // Write data
  output logic [pme_wake_pkg::DATA_W-1:0] prdata_o, // Read data
  output logic                           pready_o,  // Ready
  output logic                           pslverr_o, // Error
  reg_access_if.bus_side                 regs       // Register core
);
  import pme_wake_pkg::*;

  logic  setup;
  logic  aligned;

  assign setup      = psel_i & ~penable_i;
  assign aligned    = (paddr_i[1:0] == 2'h0);
  assign regs.idx   = addr_t'(paddr_i >> 2);
  assign regs.wdata = pwdata_i[REG_W-1:0];
  assign regs.wr_en = psel_i & penable_i & pwrite_i & pready_o
                      & ~pslverr_o;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~(aligned & regs.hit);
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= '0;
    end else if (setup) begin
      prdata_o <= (!pwrite_i && aligned && regs.hit)
                  ? {{(DATA_W-REG_W){1'b0}}, regs.rdata} : '0;
    end
  end

endmodule : apb_reg_slave

// ===== hw/sticky_capture.sv
/*
 * Sticky event bits: a high set input latches the bit, a write of one
 * clears it, and a set in the same cycle wins over the clear.
 * Assumes set inputs are already in the clock domain.
 */
`timescale 1ns/1ps
module sticky_capture #(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  input  wire logic             mclk_i,    // Clock
  input  wire logic             sys_rst_i, // Async reset
  input  wire logic [WIDTH-1:0] set_i,     // Event levels
  input  wire logic [WIDTH-1:0] clr_i,     // Write-one-to-clear mask
  output logic      [WIDTH-1:0] sts_o      // Sticky status
);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sts_o <= RST;
    end else begin
      sts_o <= (sts_o & ~clr_i) | set_i;
    end
  end

endmodule : sticky_capture

// ===== hw/pme_wake_status_enable.sv
/*
 * Wake and interrupt-event status/enable block with APB registers,
 * sticky event capture and the active-low wake output.
 * Assumes sys_rst_i is the standby-power reset; main-supply, hard and
 * soft resets arrive as pins and only force the parallel status bit.
 */
// Function
// R01: Event status bits record events regardless of any enable bit.
// R02: An asserted event holds its status bit at one until cleared.
// R03: Parallel status bit reads one while the parallel port is inactive.
// R04: With the port active, the parallel bit tracks the acknowledge pin.
// R05: Bits 1-7: serial 2, serial 1, floppy, mouse, keys, watchdog, two-wire.
// R06: Status bits above zero survive main, soft and hard resets.
// R07: Writing one clears a status bit; writing zero leaves it alone.
// R08: Status resets to 01 on standby reset; bit zero set by other resets.
// R09: Wake output low when enable, status and global enable are all one.
// R10: A disabled source still records status but never drives wake.
// R11: Enables: port bit a, port bit b, ring 1, keys, mouse, key, fan, ring 2.
// R12: Enable register clears on standby reset, survives other resets.
`timescale 1ns/1ps
module pme_wake_status_enable (
  input  wire logic                mclk_i,      // 100 MHz clock
  input  wire logic                sys_rst_i,   // Standby-power reset
  // APB
  input  wire logic                psel_i,      // Select
  input  wire logic                penable_i,   // Access phase
  input  wire logic                pwrite_i,    // Write
  input  wire pme_wake_pkg::addr_t paddr_i,     // Byte address
  input  wire logic [31:0]         pwdata_i,    // Write data
  output logic [31:0]              prdata_o,    // Read data
  output logic                     pready_o,    // Ready
  output logic                     pslverr_o,   // Error
  // Reset pins that only force the parallel status bit
  input  wire logic                main_por_i,  // Main-supply POR
  input  wire logic                hard_rst_i,  // Hard reset
  input  wire logic                soft_rst_i,  // Soft reset
  // Interrupt-event sources (same clock domain)
  input  wire logic                parallel_active_i,    // Port activated
  input  wire logic                ack_n_i,              // Printer ack pin
  input  wire logic                serial_two_irq_event_i, // Serial 2
  input  wire logic                serial_one_irq_event_i, // Serial 1
  input  wire logic                floppy_irq_event_i,   // Floppy
  input  wire logic                pointer_irq_event_i,  // Mouse
  input  wire logic                keys_irq_event_i,     // Keyboard
  input  wire logic                watchdog_event_i,     // Watchdog
  input  wire logic                two_wire_event_i,     // SMBus
  // Wake source pins
  input  wire logic                kbc_port_bit_a_i,     // Port bit a
  input  wire logic                kbc_port_bit_b_i,     // Port bit b
  input  wire logic                ring_indicator_one_n_i, // Ring one
  input  wire logic                keys_wake_i,          // Keyboard
  input  wire logic                pointer_wake_i,       // Mouse
  input  wire logic                specific_key_wake_i,  // Specific key
  input  wire logic                tachometer_wake_i,    // Tachometer_wake
  input  wire logic                ring_indicator_two_n_i, // Ring two
  // Outputs
  output logic                     wake_out_n_o, // Wake, active low
  output logic                     irq_o         // Event interrupt
);
  import pme_wake_pkg::*;

  localparam int NPIN = 12;
  // Acknowledge pin idles high: no false low on bit zero after reset
  localparam logic [NPIN-1:0] SYNC_RST = 12'h100;

  reg_access_if regs ();

  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] pins;
  reg8_t           wake_pins;
  logic            ack_n_s;
  logic            any_rst_s;
  reg8_t           wr_mask;
  logic            wr_evt;
  logic            wr_wake_sts;
  reg8_t           evt_sts;
  reg8_t           evt_set;
  logic [7:1]      evt_hi;
  logic [7:1]      evt_hold;
  logic            parallel_r;
  reg8_t           wake_sts;
  reg8_t           wake_en_r;
  reg8_t           glb_ctrl_r;
  reg8_t           irq_mask_r;

  ////////////////////////////////////////////////////////////////////
  // Bus slave
  apb_reg_slave u_apb (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .regs      (regs.bus_side)
  );

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pins = {main_por_i, hard_rst_i, soft_rst_i, ack_n_i,
                 ~ring_indicator_two_n_i, tachometer_wake_i,
                 specific_key_wake_i, pointer_wake_i, keys_wake_i,
                 ~ring_indicator_one_n_i, kbc_port_bit_b_i,
                 kbc_port_bit_a_i};

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  assign wake_pins = sync2_r[7:0];                        // [R11]
  assign ack_n_s   = sync2_r[8];
  assign any_rst_s = |sync2_r[11:9];

  ////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_mask     = regs.wdata;
  assign wr_evt      = regs.wr_en && (regs.idx == IDX_EVT_STS);
  assign wr_wake_sts = regs.wr_en && (regs.idx == IDX_WAKE_STS);

  ////////////////////////////////////////////////////////////////////
  // Interrupt-event status, bits 7..1
  assign evt_hi = {two_wire_event_i, watchdog_event_i,
                   keys_irq_event_i, pointer_irq_event_i,
                   floppy_irq_event_i, serial_one_irq_event_i,
                   serial_two_irq_event_i};               // [R05] [R01]

  sticky_capture #(
    .WIDTH (7),
    .RST   (EVT_STS_RST[7:1])                             // [R08]
  ) u_evt (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),                               // [R06]
    .set_i     (evt_hi),                                  // [R02]
    .clr_i     (wr_evt ? wr_mask[7:1] : 7'h00),           // [R07]
    .sts_o     (evt_hold)
  );

  // Parallel bit: forced high when inactive or on any lesser reset
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      parallel_r <= EVT_STS_RST[BIT_PARALLEL];            // [R08]
    end else if (any_rst_s || !parallel_active_i) begin
      parallel_r <= 1'b1;                                 // [R03] [R08]
    end else if (wr_evt && wr_mask[BIT_PARALLEL] && !ack_n_s) begin
      parallel_r <= 1'b0;                                 // [R07]
    end else begin
      parallel_r <= ack_n_s;                              // [R04]
    end
  end

  assign evt_sts = {evt_hold, parallel_r};
  assign evt_set = evt_sts;

  ////////////////////////////////////////////////////////////////////
  // Wake source status
  sticky_capture #(
    .WIDTH (REG_W),
    .RST   (WAKE_STS_RST)
  ) u_wake (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (wake_pins),                               // [R10]
    .clr_i     (wr_wake_sts ? wr_mask : 8'h00),
    .sts_o     (wake_sts)
  );

  ////////////////////////////////////////////////////////////////////
  // Control registers, cleared only by the standby reset
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_en_r <= WAKE_EN_RST;                           // [R12]
    end else if (regs.wr_en && regs.idx == IDX_WAKE_EN) begin
      wake_en_r <= regs.wdata;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      glb_ctrl_r <= GLB_CTRL_RST;
    end else if (regs.wr_en && regs.idx == IDX_GLB_CTRL) begin
      glb_ctrl_r <= regs.wdata & 8'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (regs.wr_en && regs.idx == IDX_IRQ_MASK) begin
      irq_mask_r <= regs.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    regs.hit   = 1'b1;
    regs.rdata = '0;
    unique case (regs.idx)
      IDX_EVT_STS:  regs.rdata = evt_set;
      IDX_WAKE_EN:  regs.rdata = wake_en_r;
      IDX_WAKE_STS: regs.rdata = wake_sts;
      IDX_GLB_CTRL: regs.rdata = glb_ctrl_r;
      IDX_IRQ_MASK: regs.rdata = irq_mask_r;
      default:      regs.hit   = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_out_n_o <= 1'b1;
    end else begin
      wake_out_n_o <= ~(glb_ctrl_r[BIT_GLB_EN]
                        & |(wake_en_r & wake_sts));       // [R09] [R10]
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(evt_set & irq_mask_r);
    end
  end

endmodule : pme_wake_status_enable

// ===== bench/pme_wake_asserts.sv
/*
 * Port-level checker for the wake-event block, bound to its top.
 * Assumes one clock and the standby reset as the only reset.
 */
`timescale 1ns/1ps
module pme_wake_asserts (
  input wire logic                mclk_i,            // Clock
  input wire logic                sys_rst_i,         // Reset
  input wire logic                psel_i,            // Select
  input wire logic                penable_i,         // Access
  input wire logic                pwrite_i,          // Write
  input wire pme_wake_pkg::addr_t paddr_i,           // Address
  input wire logic [31:0]         prdata_o,          // Read data
  input wire logic                pready_o,          // Ready
  input wire logic                pslverr_o,         // Error
  input wire logic                parallel_active_i, // Port on
  input wire logic                keys_irq_event_i,  // Key event
  input wire logic                wake_out_n_o,      // Wake
  input wire logic                irq_o              // Interrupt
);
  import pme_wake_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic setup_c;
  logic rd_sts_c;
  assign setup_c  = psel_i && !penable_i;
  assign rd_sts_c = setup_c && !pwrite_i && paddr_i == 8'h24;

  a_ready_after_setup: assert property (setup_c |=> pready_o)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (setup_c &&
    !(paddr_i inside {8'h24, 8'h28, 8'h40, 8'h44, 8'h48})
    |=> pslverr_o && pready_o)
    else $error("unmapped address not refused");
  a_mapped_no_err: assert property (setup_c && paddr_i == 8'h28
    |=> !pslverr_o)
    else $error("mapped address refused");
  a_err_reads_zero: assert property (pslverr_o |-> prdata_o == 32'h0)
    else $error("refused access returned data");
  a_upper_bits_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_par_idle_one: assert property (
    !parallel_active_i [*3] ##0 rd_sts_c &&
    !$past(pwrite_i && penable_i) |=> prdata_o[0])
    else $error("parallel bit not one while port off");
  a_keys_sticky: assert property (
    rd_sts_c && $past(keys_irq_event_i, 2) &&
    !$past(psel_i && penable_i && pwrite_i) && !$past(sys_rst_i)
    && !$past(sys_rst_i, 2) |=> prdata_o[5])
    else $error("keyboard event bit not held");
  a_reset_quiet: assert property ($fell(sys_rst_i) |-> wake_out_n_o &&
    !irq_o && !pready_o)
    else $error("outputs active after reset");

  c_wake: cover property (!wake_out_n_o);
  c_irq: cover property (irq_o);
  c_refused: cover property (pready_o && pslverr_o);
endmodule : pme_wake_asserts

bind pme_wake_status_enable pme_wake_asserts pme_wake_asserts_i (
  .mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .parallel_active_i,
  .keys_irq_event_i, .wake_out_n_o, .irq_o);

// ===== bench/chipset_wake_model.sv
/*
 * Chipset side of the wake line: registers each cycle's wake request.
 * Assumes the wake line is a clean level in the block's clock domain.
 */
`timescale 1ns/1ps
module chipset_wake_model (
  input  wire logic mclk_i,    // Clock
  input  wire logic sys_rst_i, // Reset
  input  wire logic wake_n_i,  // Wake line, active low
  output logic      wake_req_o // Wake seen
);
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_req_o <= 1'b0;
    end else begin
      wake_req_o <= !wake_n_i;
    end
  end
endmodule : chipset_wake_model

// ===== bench/pme_wake_status_enable_bench.sv
/*
 * Self-checking bench: APB driver with expectation queues and a monitor.
 * Assumes the design, its package and the checker are compiled first.
 */
`timescale 1ns/1ps
module pme_wake_status_enable_bench;
  import pme_wake_pkg::*;
  logic        mclk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, pready_o, pslverr_o, wake_out_n_o, irq_o;
  addr_t       paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic [2:0]  rst_pins = '0;
  logic        par_act = 0, ack_n = 1, probe = 0, wake_req;
  logic [7:1]  evt = '0;
  logic [7:0]  wk = '0, r;
  logic [8:0]  rd_q[$];
  logic [1:0]  out_q[$];
  int          error_cnt = 0, samples_checked = 0, cyc = 0;

  always #5 mclk_i = !mclk_i;
  pme_wake_status_enable pme_wake_status_enable_i (
    .mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .main_por_i(rst_pins[0]), .hard_rst_i(rst_pins[1]),
    .soft_rst_i(rst_pins[2]), .parallel_active_i(par_act), .ack_n_i(ack_n),
    .serial_two_irq_event_i(evt[1]), .serial_one_irq_event_i(evt[2]),
    .floppy_irq_event_i(evt[3]), .pointer_irq_event_i(evt[4]),
    .keys_irq_event_i(evt[5]), .watchdog_event_i(evt[6]),
    .two_wire_event_i(evt[7]), .kbc_port_bit_a_i(wk[0]),
    .kbc_port_bit_b_i(wk[1]), .ring_indicator_one_n_i(!wk[2]),
    .keys_wake_i(wk[3]), .pointer_wake_i(wk[4]),
    .specific_key_wake_i(wk[5]), .tachometer_wake_i(wk[6]),
    .ring_indicator_two_n_i(!wk[7]), .wake_out_n_o, .irq_o);
  chipset_wake_model chipset_wake_model_i (
    .mclk_i, .sys_rst_i, .wake_n_i(wake_out_n_o), .wake_req_o(wake_req));
////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input addr_t a, input logic [7:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    tick(1);
    penable_i <= 1;
    do begin
      tick(1);
    end while (pready_o !== 1'b1);
    psel_i <= 0;
    penable_i <= 0;
    tick(1);
  endtask : apb

  task automatic wr(input addr_t a, input logic [7:0] d);
    apb(1, a, d);
  endtask : wr

  task automatic rd(input addr_t a, input logic [7:0] e, input logic err);
    rd_q.push_back({err, e});
    apb(0, a, 8'h00);
  endtask : rd

  task automatic look(input logic [1:0] e);
    out_q.push_back(e);
    probe <= 1;
    tick(1);
    probe <= 0;
  endtask : look

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  always @(negedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      chk({pslverr_o, prdata_o[7:0]}, rd_q.pop_front());
    end
    if (probe) begin
      chk({7'h0, irq_o, wake_req}, {7'h0, out_q.pop_front()});
    end
  end

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc > 4000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(54));
    tick(20);
    sys_rst_i <= 0;
    tick(1);
    rd(8'h24, 8'h01, 0);
    rd(8'h28, 8'h00, 0);
    rd(8'h4c, 8'h00, 1);
    rd(8'h25, 8'h00, 1);
    $display("reset values done");
    par_act <= 1;
    ack_n <= 0;
    tick(5);
    for (int i = 1; i < 8; i++) begin
      evt[i] <= 1;
      tick(1);
      evt <= '0;
      tick(1);
      rd(8'h24, 8'((2 << i) - 2), 0);
    end
    r = 8'($urandom);
    wr(8'h24, r);
    rd(8'h24, 8'hfe & ~r, 0);
    wr(8'h24, 8'h00);
    rd(8'h24, 8'hfe & ~r, 0);
    wr(8'h24, 8'hff);
    ack_n <= 1;
    tick(5);
    rd(8'h24, 8'h01, 0);
    ack_n <= 0;
    tick(5);
    rd(8'h24, 8'h00, 0);
    par_act <= 0;
    tick(5);
    rd(8'h24, 8'h01, 0);
    $display("event status done");
    par_act <= 1;
    evt <= 7'h24;
    tick(1);
    evt <= '0;
    wr(8'h28, r);
    for (int k = 0; k < 3; k++) begin
      rst_pins[k] <= 1;
      tick(4);
      rd(8'h24, 8'h49, 0);
      rst_pins <= '0;
      tick(5);
      rd(8'h24, 8'h48, 0);
    end
    rd(8'h28, r, 0);
    wr(8'h24, 8'hff);
    $display("pin resets done");
    wr(8'h28, 8'hff);
    wk <= 8'($urandom_range(255, 1));
    tick(1);
    wk <= '0;
    tick(6);
    look(2'b00);
    wr(8'h44, 8'h01);
    tick(3);
    look(2'b01);
    wr(8'h40, 8'hff);
    wr(8'h28, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h28, 8'h01 << i);
      wk[i] <= 1;
      tick(1);
      wk <= '0;
      tick(6);
      look(2'b01);
      wr(8'h28, 8'h00);
      tick(3);
      look(2'b00);
      rd(8'h40, 8'h01 << i, 0);
      wr(8'h40, 8'hff);
    end
    $display("wake output done");
    evt[7] <= 1;
    tick(1);
    evt <= '0;
    tick(3);
    look(2'b00);
    wr(8'h48, 8'h80);
    tick(3);
    look(2'b10);
    wr(8'h24, 8'h80);
    tick(3);
    look(2'b00);
    $display("interrupt done");
    ack_n <= 1;
    wr(8'h28, r | 8'h01);
    evt[4] <= 1;
    tick(1);
    evt <= '0;
    sys_rst_i <= 1;
    tick(2);
    sys_rst_i <= 0;
    tick(1);
    rd(8'h24, 8'h01, 0);
    rd(8'h28, 8'h00, 0);
    look(2'b00);
    $display("standby reset done");
    complete_run();
  end
endmodule : pme_wake_status_enable_bench
